//--- design/flash_cycle_engine.sv
`default_nettype none

module flash_cycle_engine (
  input  wire logic                              i_clk,
  input  wire logic                              i_rst,
  flash_cycle_if.engine                          bus,
  input  wire logic [flash_host_pkg::DATA_W-1:0] i_dq,
  output logic      [flash_host_pkg::DATA_W-1:0] o_dq,
  output logic                                   o_dq_oe_n,
  output logic      [flash_host_pkg::ADDR_W-1:0] o_addr,
  output logic                                   o_ce_n,
  output logic                                   o_oe_n,
  output logic                                   o_we_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    E_IDLE   = 5'b00001,
    E_SETUP  = 5'b00010,
    E_STROBE = 5'b00100,
    E_HOLD   = 5'b01000,
    E_READ   = 5'b10000
  } eng_state_t;

  eng_state_t                        state,  next_state;
  logic [3:0]                        cnt,    next_cnt;
  logic [flash_host_pkg::DATA_W-1:0] dq_meta, dq_sync;
  logic [flash_host_pkg::DATA_W-1:0] next_dq,  next_rdata;
  logic [flash_host_pkg::ADDR_W-1:0] next_addr;
  logic                              next_dq_oe_n, next_ce_n, next_oe_n, next_we_n, next_ack;

  localparam logic [3:0] PHASE_LAST = 4'(flash_host_pkg::PHASE_CYCLES - 1);
  localparam logic [3:0] READ_LAST  = 4'(flash_host_pkg::READ_WAIT_CYCLES - 1);

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_cnt     = cnt + 4'h1;
    next_dq      = o_dq;
    next_dq_oe_n = o_dq_oe_n;
    next_addr    = o_addr;
    next_ce_n    = o_ce_n;
    next_oe_n    = o_oe_n;
    next_we_n    = o_we_n;
    next_ack     = 1'b0;
    next_rdata   = bus.rdata;
    case (state)
      E_IDLE: begin
        next_cnt = 4'h0;
        if (bus.req_valid) begin
          next_addr = bus.req_addr;
          next_dq   = bus.req_data;
          next_ce_n = 1'b0;
          if (bus.req_write) begin
            next_oe_n    = 1'b1;
            next_dq_oe_n = 1'b0;
            next_state   = E_SETUP;
          end else begin
            next_oe_n  = 1'b0;
            next_state = E_READ;
          end
        end
      end
      E_SETUP: begin
        if (cnt == PHASE_LAST) begin
          next_we_n  = 1'b0;
          next_cnt   = 4'h0;
          next_state = E_STROBE;
        end
      end
      E_STROBE: begin
        if (cnt == PHASE_LAST) begin
          next_we_n  = 1'b1;
          next_cnt   = 4'h0;
          next_state = E_HOLD;
        end
      end
      E_HOLD: begin
        if (cnt == PHASE_LAST) begin
          next_ce_n    = 1'b1;
          next_dq_oe_n = 1'b1;
          next_ack     = 1'b1;
          next_state   = E_IDLE;
        end
      end
      E_READ: begin
        // Wait covers access time plus the two sync stages
        if (cnt == READ_LAST) begin
          next_rdata = dq_sync;
          next_ce_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_ack   = 1'b1;
          next_state = E_IDLE;
        end
      end
      default: begin
        next_state = E_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state     <= E_IDLE;
      cnt       <= 4'h0;
      dq_meta   <= 8'h00;
      dq_sync   <= 8'h00;
      o_dq      <= 8'h00;
      o_dq_oe_n <= 1'b1;
      o_addr    <= 17'h00000;
      o_ce_n    <= 1'b1;
      o_oe_n    <= 1'b1;
      o_we_n    <= 1'b1;
      bus.ack   <= 1'b0;
      bus.rdata <= 8'h00;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      dq_meta   <= i_dq;
      dq_sync   <= dq_meta;
      o_dq      <= next_dq;
      o_dq_oe_n <= next_dq_oe_n;
      o_addr    <= next_addr;
      o_ce_n    <= next_ce_n;
      o_oe_n    <= next_oe_n;
      o_we_n    <= next_we_n;
      bus.ack   <= next_ack;
      bus.rdata <= next_rdata;
    end
  end

endmodule : flash_cycle_engine

`default_nettype wire

//--- design/flash_cycle_if.sv
`default_nettype none

interface flash_cycle_if;
  logic                              req_valid;
  logic                              req_write;
  logic [flash_host_pkg::ADDR_W-1:0] req_addr;
  logic [flash_host_pkg::DATA_W-1:0] req_data;
  logic                              ack;
  logic [flash_host_pkg::DATA_W-1:0] rdata;

  modport sequencer (output req_valid, output req_write, output req_addr,
                     output req_data, input ack, input rdata);
  modport engine    (input req_valid, input req_write, input req_addr,
                     input req_data, output ack, output rdata);
endinterface : flash_cycle_if

`default_nettype wire

//--- design/flash_host_ctrl.sv
`default_nettype none

module flash_host_ctrl #(
  parameter int ERASE_CYCLES = flash_host_pkg::ERASE_CYCLES
) (
  input  wire logic                              i_clk,
  input  wire logic                              i_rst,
  input  wire logic                              i_start,
  input  wire logic [2:0]                        i_op,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0] i_data,
  output logic                                   o_busy,
  output logic                                   o_done,
  output logic      [flash_host_pkg::DATA_W-1:0] o_rdata,
  output logic                                   o_verify_ok,
  output logic                                   o_parity_ok,
  output logic                                   o_vpp_high,
  output logic                                   o_id_elevated,
  output logic      [flash_host_pkg::ADDR_W-1:0] o_addr,
  output logic                                   o_ce_n,
  output logic                                   o_oe_n,
  output logic                                   o_we_n,
  input  wire logic [flash_host_pkg::DATA_W-1:0] i_dq,
  output logic      [flash_host_pkg::DATA_W-1:0] o_dq,
  output logic                                   o_dq_oe_n
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    M_IDLE  = 5'b00001,
    M_ISSUE = 5'b00010,
    M_BUS   = 5'b00100,
    M_TIMER = 5'b01000,
    M_DONE  = 5'b10000
  } seq_state_t;

  flash_cycle_if cyc ();

  seq_state_t                                     state,   next_state;
  flash_host_pkg::op_t                            op,      next_op;
  logic [flash_host_pkg::STEP_W-1:0]              step,    next_step;
  logic [flash_host_pkg::TIMER_W-1:0]             timer,   next_timer;
  logic [flash_host_pkg::ADDR_W-1:0]              addr,    next_addr;
  logic [flash_host_pkg::DATA_W-1:0]              data,    next_data;
  logic [flash_host_pkg::DATA_W-1:0]              next_rdata;
  logic                                           next_busy, next_done, next_vok, next_pok;
  logic                                           next_vpp, next_elev;
  logic                                           req_valid, next_req_valid;
  logic                                           req_write, next_req_write;
  logic [flash_host_pkg::ADDR_W-1:0]              req_addr,  next_req_addr;
  logic [flash_host_pkg::DATA_W-1:0]              req_data,  next_req_data;
  flash_host_pkg::act_t                           act;
  logic [flash_host_pkg::DATA_W-1:0]              act_code;
  logic [flash_host_pkg::ADDR_W-1:0]              id_addr;
  localparam logic [19:0] TIMER_ERASE = 20'(ERASE_CYCLES - 1);
  localparam logic [19:0] TIMER_PROG  = 20'(flash_host_pkg::PROG_CYCLES - 1);
  localparam logic [19:0] TIMER_REC   = 20'(flash_host_pkg::RECOVER_CYCLES - 1);

  assign cyc.req_valid = req_valid;
  assign cyc.req_write = req_write;
  assign cyc.req_addr  = req_addr;
  assign cyc.req_data  = req_data;

  // ----------------------------------------------------------------
  // Pin cycle engine
  // ----------------------------------------------------------------
  flash_cycle_engine u_engine (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .bus       (cyc.engine),
    .i_dq      (i_dq),
    .o_dq      (o_dq),
    .o_dq_oe_n (o_dq_oe_n),
    .o_addr    (o_addr),
    .o_ce_n    (o_ce_n),
    .o_oe_n    (o_oe_n),
    .o_we_n    (o_we_n)
  );

  // ----------------------------------------------------------------
  // Operation sequences
  // ----------------------------------------------------------------
  // other address lines low
  assign id_addr = {16'h0000, addr[0]};

  always_comb begin
    act      = flash_host_pkg::ACT_END;
    act_code = flash_host_pkg::CODE_READ;
    case (op)
      flash_host_pkg::OP_READ: begin
        if (step == 3'h0) act = flash_host_pkg::ACT_WRITE_CODE;
        if (step == 3'h1) act = flash_host_pkg::ACT_READ;
      end
      flash_host_pkg::OP_READ_ID: begin
        act_code = flash_host_pkg::CODE_IDENT;
        if (step == 3'h0) act = flash_host_pkg::ACT_WRITE_CODE;
        if (step == 3'h1) act = flash_host_pkg::ACT_READ;
      end
      flash_host_pkg::OP_HW_ID: begin
        if (step == 3'h0) act = flash_host_pkg::ACT_READ;
      end
      flash_host_pkg::OP_ERASE: begin
        act_code = flash_host_pkg::CODE_ERASE;
        case (step)
          3'h0: act = flash_host_pkg::ACT_WRITE_CODE;
          3'h1: act = flash_host_pkg::ACT_WRITE_CODE;
          3'h2: act = flash_host_pkg::ACT_WAIT_ERASE;
          3'h3: act = flash_host_pkg::ACT_WRITE_DATA;
          3'h4: act = flash_host_pkg::ACT_WAIT_REC;
          3'h5: act = flash_host_pkg::ACT_READ;
          default: act = flash_host_pkg::ACT_END;
        endcase
      end
      flash_host_pkg::OP_ERASE_VERIFY: begin
        case (step)
          3'h0: act = flash_host_pkg::ACT_WRITE_DATA;
          3'h1: act = flash_host_pkg::ACT_WAIT_REC;
          3'h2: act = flash_host_pkg::ACT_READ;
          default: act = flash_host_pkg::ACT_END;
        endcase
      end
      flash_host_pkg::OP_PROGRAM: begin
        act_code = (step == 3'h0) ? flash_host_pkg::CODE_PROGRAM
                                  : flash_host_pkg::CODE_PROG_VERIFY;
        case (step)
          3'h0: act = flash_host_pkg::ACT_WRITE_CODE;
          3'h1: act = flash_host_pkg::ACT_WRITE_DATA;
          3'h2: act = flash_host_pkg::ACT_WAIT_PROG;
          3'h3: act = flash_host_pkg::ACT_WRITE_CODE;
          3'h4: act = flash_host_pkg::ACT_WAIT_REC;
          3'h5: act = flash_host_pkg::ACT_READ;
          default: act = flash_host_pkg::ACT_END;
        endcase
      end
      flash_host_pkg::OP_RESET: begin
        act_code = flash_host_pkg::CODE_RESET;
        if (step == 3'h0 || step == 3'h1) act = flash_host_pkg::ACT_WRITE_CODE;
      end
      default: begin
        act = flash_host_pkg::ACT_END;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer next values
  // ----------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_op        = op;
    next_step      = step;
    next_timer     = timer;
    next_addr      = addr;
    next_data      = data;
    next_rdata     = o_rdata;
    next_busy      = o_busy;
    next_done      = 1'b0;
    next_vok       = o_verify_ok;
    next_pok       = o_parity_ok;
    next_vpp       = o_vpp_high;
    next_elev      = o_id_elevated;
    next_req_valid = 1'b0;
    next_req_write = req_write;
    next_req_addr  = req_addr;
    next_req_data  = req_data;
    case (state)
      M_IDLE: begin
        if (i_start) begin
          next_op    = flash_host_pkg::op_t'(i_op);
          next_addr  = i_addr;
          next_data  = i_data;
          next_step  = 3'h0;
          next_busy  = 1'b1;
          next_vpp   = (i_op != 3'(flash_host_pkg::OP_HW_ID));
          next_elev  = (i_op == 3'(flash_host_pkg::OP_HW_ID));
          next_state = M_ISSUE;
        end
      end
      M_ISSUE: begin
        next_state = M_BUS;
        case (act)
          flash_host_pkg::ACT_WRITE_CODE: begin
            next_req_valid = 1'b1;
            next_req_write = 1'b1;
            next_req_addr  = addr;
            next_req_data  = act_code;
          end
          flash_host_pkg::ACT_WRITE_DATA: begin
            // verify code with address ends erase
            next_req_valid = 1'b1;
            next_req_write = 1'b1;
            next_req_addr  = addr;
            next_req_data  = (op == flash_host_pkg::OP_PROGRAM) ? data
                             : flash_host_pkg::CODE_ERASE_VERIFY;
          end
          flash_host_pkg::ACT_READ: begin
            next_req_valid = 1'b1;
            next_req_write = 1'b0;
            next_req_addr  = (op == flash_host_pkg::OP_READ) ? addr : id_addr;
          end
          flash_host_pkg::ACT_WAIT_ERASE: begin
            // host bounds the erase pulse too
            next_timer = TIMER_ERASE;
            next_state = M_TIMER;
          end
          flash_host_pkg::ACT_WAIT_PROG: begin
            next_timer = TIMER_PROG;
            next_state = M_TIMER;
          end
          flash_host_pkg::ACT_WAIT_REC: begin
            next_timer = TIMER_REC;
            next_state = M_TIMER;
          end
          default: begin
            next_state = M_DONE;
          end
        endcase
      end
      M_BUS: begin
        if (cyc.ack) begin
          next_step = step + 3'h1;
          if (!req_write) begin
            next_rdata = cyc.rdata;
            next_pok   = ^cyc.rdata;
            next_vok   = (op == flash_host_pkg::OP_PROGRAM) ? (cyc.rdata == data)
                         : (op == flash_host_pkg::OP_ERASE
                            || op == flash_host_pkg::OP_ERASE_VERIFY)
                         ? (cyc.rdata == flash_host_pkg::ERASED_BYTE) : 1'b1;
          end
          next_state = M_ISSUE;
        end
      end
      M_TIMER: begin
        next_timer = timer - 20'h00001;
        if (timer == 20'h00000) begin
          next_step  = step + 3'h1;
          next_state = M_ISSUE;
        end
      end
      M_DONE: begin
        // dropping supply returns device to read mode
        next_vpp   = 1'b0;
        next_elev  = 1'b0;
        next_busy  = 1'b0;
        next_done  = 1'b1;
        next_state = M_IDLE;
      end
      default: begin
        next_state = M_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state         <= M_IDLE;
      op            <= flash_host_pkg::OP_READ;
      step          <= 3'h0;
      timer         <= 20'h00000;
      addr          <= 17'h00000;
      data          <= 8'h00;
      o_rdata       <= 8'h00;
      o_busy        <= 1'b0;
      o_done        <= 1'b0;
      o_verify_ok   <= 1'b0;
      o_parity_ok   <= 1'b0;
      o_vpp_high    <= 1'b0;
      o_id_elevated <= 1'b0;
      req_valid     <= 1'b0;
      req_write     <= 1'b0;
      req_addr      <= 17'h00000;
      req_data      <= 8'h00;
    end else begin
      state         <= next_state;
      op            <= next_op;
      step          <= next_step;
      timer         <= next_timer;
      addr          <= next_addr;
      data          <= next_data;
      o_rdata       <= next_rdata;
      o_busy        <= next_busy;
      o_done        <= next_done;
      o_verify_ok   <= next_vok;
      o_parity_ok   <= next_pok;
      o_vpp_high    <= next_vpp;
      o_id_elevated <= next_elev;
      req_valid     <= next_req_valid;
      req_write     <= next_req_write;
      req_addr      <= next_req_addr;
      req_data      <= next_req_data;
    end
  end

endmodule : flash_host_ctrl

`default_nettype wire

//--- design/flash_host_pkg.sv
`default_nettype none

package flash_host_pkg;

  // ----------------------------------------------------------------
  // Array and bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Command codes written into the device command register, and the erased byte value
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_READ         = 8'h00;
  localparam logic [7:0] CODE_READ_ALT     = 8'hff;
  localparam logic [7:0] CODE_IDENT        = 8'h90;
  localparam logic [7:0] CODE_IDENT_ALT    = 8'h80;
  localparam logic [7:0] CODE_ERASE        = 8'h20;
  localparam logic [7:0] CODE_ERASE_VERIFY = 8'ha0;
  localparam logic [7:0] CODE_PROGRAM      = 8'h40;
  localparam logic [7:0] CODE_PROG_VERIFY  = 8'hc0;
  localparam logic [7:0] CODE_RESET        = 8'hff;
  localparam logic [7:0] ERASED_BYTE       = 8'hff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int ERASE_TIME_US    = 10000;
  localparam int ERASE_CYCLES     = ERASE_TIME_US * CLK_MHZ;
  localparam int RECOVER_TIME_US  = 6;
  localparam int RECOVER_CYCLES   = RECOVER_TIME_US * CLK_MHZ;
  localparam int PROG_CYCLES      = 1000;
  localparam int PHASE_CYCLES     = 2;
  localparam int READ_WAIT_CYCLES = 6;
  localparam int TIMER_W          = 20;
  localparam int STEP_W           = 3;

  // ----------------------------------------------------------------
  // User operations and sequence actions
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ         = 3'h0,
    OP_READ_ID      = 3'h1,
    OP_HW_ID        = 3'h2,
    OP_ERASE        = 3'h3,
    OP_ERASE_VERIFY = 3'h4,
    OP_PROGRAM      = 3'h5,
    OP_RESET        = 3'h6
  } op_t;

  typedef enum logic [2:0] {
    ACT_WRITE_CODE = 3'h0,
    ACT_WRITE_DATA = 3'h1,
    ACT_READ       = 3'h2,
    ACT_WAIT_ERASE = 3'h3,
    ACT_WAIT_PROG  = 3'h4,
    ACT_WAIT_REC   = 3'h5,
    ACT_END        = 3'h6
  } act_t;

endpackage : flash_host_pkg

`default_nettype wire

//--- dv/flash_dev_model.sv
`default_nettype none
module flash_dev_model (
  input  wire logic        i_vpp_high,
  input  wire logic        i_id_elevated,
  input  wire logic [16:0] i_addr,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [7:0]  i_dq,
  output logic      [7:0]  o_dq
);
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identifier values
  localparam logic [7:0] MAKER_ID = 8'h02;
  localparam logic [7:0] PART_ID  = 8'h34;
  // Small array; upper address bits alias
  logic [7:0]  mem [8] = '{default: 8'h00};
  logic [7:0]  cmd      = 8'h00;
  logic [7:0]  last     = 8'h00;
  logic [7:0]  val;
  logic [16:0] lat;
  logic [16:0] pa;
  logic [16:0] ea;
  always @(negedge i_we_n or negedge i_ce_n) if (!i_we_n && !i_ce_n) lat = i_addr;
  always @(posedge i_we_n) begin
    if (i_vpp_high && !i_ce_n && i_oe_n) begin
      if (cmd == 8'h40) begin
        mem[lat[2:0]] = i_dq;
        pa = lat;
        cmd = 8'h01;
      end else if (cmd == 8'h20 && i_dq == 8'h20) begin
        mem = '{default: 8'hff};
        cmd = 8'h21;
      end else begin
        cmd = i_dq;
        ea = lat;
      end
    end
  end
  always @(negedge i_vpp_high) cmd = 8'h00;
  always_comb begin
    case (cmd)
      8'h80, 8'h90: val = i_addr[0] ? PART_ID : MAKER_ID;
      8'ha0: val = mem[ea[2:0]];
      8'hc0: val = mem[pa[2:0]];
      default: val = mem[i_addr[2:0]];
    endcase
    if (i_id_elevated) val = i_addr[0] ? PART_ID : MAKER_ID;
  end
  // Released bus shows inverse so stale data never passes
  always @(posedge i_oe_n) last = val;
  assign o_dq = (!i_ce_n && !i_oe_n) ? val : ~last;
endmodule : flash_dev_model
`default_nettype wire

//--- dv/flash_host_ctrl_checker.sv
`default_nettype none
module flash_host_ctrl_checker #(
  parameter int ERASE_CYCLES = 50
) (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_vpp_high,
  input wire logic        o_id_elevated,
  input wire logic [16:0] o_addr,
  input wire logic        o_ce_n,
  input wire logic        o_oe_n,
  input wire logic        o_we_n,
  input wire logic [7:0]  o_dq,
  input wire logic        o_dq_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Cycles since the last strobe rise, and whether that rise started an erase
  logic [7:0] last_code;
  logic       erasing;
  logic       we_prev;
  int         gap;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      last_code <= 8'h00;
      erasing   <= 1'b0;
      we_prev   <= 1'b1;
      gap       <= 0;
    end else begin
      we_prev <= o_we_n;
      gap     <= (o_we_n && !we_prev) ? 0 : gap + 1;
      if (o_we_n && !we_prev) begin
        last_code <= o_dq;
        erasing   <= (last_code == 8'h20) && (o_dq == 8'h20);
      end
    end
  end
  a_write_pins: assert property (
    $fell(o_we_n) |-> !o_ce_n && o_oe_n && !o_dq_oe_n) else $error("bad write pins");
  a_strobe_width: assert property (
    $fell(o_we_n) |-> ##1 !o_we_n ##1 o_we_n) else $error("bad strobe width");
  a_latch_hold: assert property (
    (!o_we_n || $rose(o_we_n)) |-> $stable(o_addr) && $stable(o_dq)) else $error("latch moved");
  a_write_vpp: assert property (
    !o_we_n |-> o_vpp_high && !o_id_elevated) else $error("write without supply");
  a_id_pins: assert property (
    o_id_elevated |-> !o_vpp_high && (o_ce_n || o_addr[16:1] == 16'h0)) else $error("id pins");
  a_no_fight: assert property (
    !o_oe_n |-> o_dq_oe_n && o_we_n) else $error("bus contention");
  a_recover: assert property (
    $rose(o_we_n) && o_dq == 8'ha0 |-> ##1 o_oe_n [*8]) else $error("early verify read");
  a_recover_gap: assert property (
    $fell(o_oe_n) && (last_code == 8'ha0 || last_code == 8'hc0)
    |-> gap >= flash_host_pkg::RECOVER_CYCLES) else $error("short recovery");
  a_erase_bound: assert property (
    erasing |-> gap <= ERASE_CYCLES + 16) else $error("erase pulse too long");
  a_done_pulse: assert property (
    o_done |-> !o_busy && $past(o_busy) ##1 !o_done) else $error("bad done pulse");
  a_idle_pins: assert property (
    !o_busy |-> o_ce_n && o_we_n && !o_vpp_high && !o_id_elevated) else $error("idle pins");
endmodule : flash_host_ctrl_checker
bind flash_host_ctrl flash_host_ctrl_checker #(.ERASE_CYCLES(ERASE_CYCLES)) chk_i (
  .i_clk, .i_rst, .o_busy, .o_done, .o_vpp_high, .o_id_elevated, .o_addr, .o_ce_n,
  .o_oe_n, .o_we_n, .o_dq, .o_dq_oe_n);
`default_nettype wire

//--- dv/tb_flash_host_ctrl.sv
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_flash_host_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // Same arbitrary identifiers as the device model
  localparam logic [7:0] MAKER = 8'h02;
  localparam logic [7:0] PART  = 8'h34;
  typedef struct packed {logic [2:0] op; logic [16:0] a; logic [7:0] d, r;} row_t;
  logic        i_clk = 0, i_rst = 1, i_start = 0;
  logic [2:0]  i_op = 0;
  logic [16:0] i_addr = 0, o_addr;
  logic [7:0]  i_data = 0, i_dq, o_dq, o_rdata, dev_dq;
  logic        o_busy, o_done, o_verify_ok, o_parity_ok, o_vpp_high, o_id_elevated;
  logic        o_ce_n, o_oe_n, o_we_n, o_dq_oe_n;
  int          n_mismatch = 0, n_compared = 0;
  // zero fill of the whole model array before the erase row
  row_t        rows [19] = '{
    '{3'h5, 17'h3, 8'h5a, 8'h5a}, '{3'h0, 17'h3, 8'h0, 8'h5a}, '{3'h0, 17'h4, 8'h0, 8'h00},
    '{3'h1, 17'h0, 8'h0, MAKER}, '{3'h1, 17'h1, 8'h0, PART}, '{3'h2, 17'h0, 8'h0, MAKER},
    '{3'h2, 17'h1, 8'h0, PART}, '{3'h5, 17'h0, 8'h0, 8'h0}, '{3'h5, 17'h1, 8'h0, 8'h0},
    '{3'h5, 17'h2, 8'h0, 8'h0}, '{3'h5, 17'h3, 8'h0, 8'h0}, '{3'h5, 17'h4, 8'h0, 8'h0},
    '{3'h5, 17'h5, 8'h0, 8'h0}, '{3'h5, 17'h6, 8'h0, 8'h0}, '{3'h5, 17'h7, 8'h0, 8'h0},
    '{3'h3, 17'h3, 8'h0, 8'hff}, '{3'h4, 17'h4, 8'h0, 8'hff},
    '{3'h6, 17'h0, 8'h0, 8'hff}, '{3'h0, 17'h3, 8'h0, 8'hff}};
  always #5 i_clk = ~i_clk;
  assign i_dq = !o_dq_oe_n ? o_dq : dev_dq;
  flash_host_ctrl #(.ERASE_CYCLES(50)) flash_host_ctrl_i (.i_clk, .i_rst, .i_start, .i_op,
    .i_addr, .i_data, .o_busy, .o_done, .o_rdata, .o_verify_ok, .o_parity_ok, .o_vpp_high,
    .o_id_elevated, .o_addr, .o_ce_n, .o_oe_n, .o_we_n, .i_dq, .o_dq, .o_dq_oe_n);
  flash_dev_model flash_dev_model_i (.i_vpp_high(o_vpp_high), .i_id_elevated(o_id_elevated),
    .i_addr(o_addr), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_dq(i_dq),
    .o_dq(dev_dq));
  task automatic go(input logic [2:0] op, input logic [16:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_start <= 1;
    i_op <= op;
    i_addr <= a;
    i_data <= d;
    @(posedge i_clk);
    i_start <= 0;
  endtask : go
  // Bounded wait, sampled mid-cycle; a hang ends the run as a failure
  task automatic wait_done();
    int n;
    n = 0;
    while (o_done !== 1'b1 && n < 5000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 5000) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wait_done
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 0;
    `CHK("busy after reset", 1'b0, o_busy)
    `CHK("vpp after reset", 1'b0, o_vpp_high)
    foreach (rows[k]) begin
      go(rows[k].op, rows[k].a, rows[k].d);
      wait_done();
      `CHK("rdata", rows[k].r, o_rdata)
      `CHK("verify", 1'b1, o_verify_ok)
      `CHK("parity", ^rows[k].r, o_parity_ok)
      $display("row %0d done", k);
    end
    go(3'h5, 17'h6, 8'h77);
    repeat (20) @(posedge i_clk);
    i_start <= 1;
    i_op <= 3'h0;
    @(posedge i_clk);
    i_start <= 0;
    wait_done();
    `CHK("start ignored while busy", 8'h77, o_rdata)
    go(3'h7, 17'h0, 8'h0);
    wait_done();
    `CHK("unknown op keeps data", 8'h77, o_rdata)
    $display("refusal test done");
    go(3'h3, 17'h3, 8'h0);
    repeat (30) @(posedge i_clk);
    i_rst <= 1;
    @(posedge i_clk);
    i_rst <= 0;
    `CHK("supply dropped by reset", 1'b0, o_vpp_high)
    go(3'h0, 17'h6, 8'h0);
    wait_done();
    `CHK("read after aborted erase", 8'hff, o_rdata)
    $display("mid reset test done");
    complete_run();
  end
endmodule : tb_flash_host_ctrl
`default_nettype wire
